// file: common/asss_pkg.sv
// Constants and carrier types of the ADC sample streaming port.
// Assumes one 200 MHz clock and a host-driven mode 0 serial link.
package asss_pkg;

   // ---------------------------------------------
   // Clock and link timing
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS       = 5;
   localparam int LINK_CLK_MIN_PER_NS = 1000;
   localparam int LINK_HALF_CYC       = LINK_CLK_MIN_PER_NS / (2 * CLK_PERIOD_NS);
   localparam int SYNC_STAGES         = 2;

   // ---------------------------------------------
   // Frame layout
   // ---------------------------------------------
   localparam int WORD_BITS    = 16;
   localparam int NUM_WORDS    = 5;
   localparam int FRAME_BITS   = 80;
   localparam int BIT_IDX_W    = 7;
   localparam int AVG_LOG2_W   = 3;
   localparam int AVG_MAX_LOG2 = 7;
   localparam int AVG_CNT_W    = 8;
   localparam int ACC_W        = WORD_BITS + AVG_MAX_LOG2;

   // ---------------------------------------------
   // Reset values and fixed register constants
   // ---------------------------------------------
   localparam logic [BIT_IDX_W-1:0] BIT_IDX_RST  = 7'h00;
   localparam logic [BIT_IDX_W-1:0] BIT_IDX_LAST = 7'h4F;
   localparam logic [AVG_CNT_W-1:0] AVG_CNT_RST  = 8'h00;
   localparam logic [AVG_CNT_W-1:0] AVG_CNT_ONE  = 8'h01;
   localparam logic [ACC_W-1:0]     ACC_RST      = 23'h00_0000;
   localparam logic [FRAME_BITS-1:0] FRAME_RST   = 80'h0000_0000_0000_0000_0000;
   // Link inputs at rest: select high, shift clock low.
   localparam logic [1:0]           LINK_SYNC_RST = 2'h2;

   // One sample set, current first so it leaves the port first.
   typedef struct packed {
      logic [WORD_BITS-1:0] current;
      logic [WORD_BITS-1:0] vin;
      logic [WORD_BITS-1:0] vout;
      logic [WORD_BITS-1:0] temp;
      logic [WORD_BITS-1:0] power;
   } asss_sample_t;

   // Host-driven link inputs.
   typedef struct packed {
      logic select_n;
      logic clock;
   } asss_link_t;

   // Monitor configuration from the management bus side.
   typedef struct packed {
      logic                  single_shot;
      logic [AVG_LOG2_W-1:0] avg_log2;
   } asss_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE  = 3'b100
   } asss_state_t;

endpackage

// file: rtl/asss_sync.sv
// Two-flop synchronisers, one per bit, for inputs from outside the clock domain.
// Assumes the bits are independent levels.
module asss_sync #(
   parameter int               WIDTH   = 2,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   import asss_pkg::*;

   logic [WIDTH-1:0] meta_reg;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("asss_sync width must be positive");
      end
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               meta_reg[i] <= RST_VAL[i];
               sync_out[i] <= RST_VAL[i];
            end else begin
               meta_reg[i] <= async_in[i];
               sync_out[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule // asss_sync

// file: rtl/asss_avg.sv
// Averager of 2^N raw ADC sample sets, continuous or single-shot.
// Assumes raw sets arrive as one-cycle valid pulses on the same clock.
module asss_avg (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Configuration and trigger
   input  wire asss_pkg::asss_cfg_t    cfg,
   input  wire logic                   start,
   // Raw ADC results
   input  wire asss_pkg::asss_sample_t raw,
   input  wire logic                   raw_valid,
   // Averaged result
   output asss_pkg::asss_sample_t      avg,
   output logic                        avg_valid
);
   import asss_pkg::*;

   // ---------------------------------------------
   // Sample counting
   // ---------------------------------------------
   logic [AVG_CNT_W-1:0]  cnt_reg;
   logic                  run_reg;
   wire  [AVG_CNT_W-1:0]  target    = AVG_CNT_ONE << cfg.avg_log2;
   wire                   take      = raw_valid & (~cfg.single_shot | run_reg);
   wire                   last      = take & (cnt_reg == target - AVG_CNT_ONE);
   wire  [FRAME_BITS-1:0] raw_flat  = raw;
   logic [FRAME_BITS-1:0] avg_flat;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_reg   <= AVG_CNT_RST;
         run_reg   <= 1'b0;
         avg_valid <= 1'b0;
      end else begin
         avg_valid <= last;
         if (start) begin
            cnt_reg <= AVG_CNT_RST;
            run_reg <= 1'b1;
         end else if (last) begin
            cnt_reg <= AVG_CNT_RST;
            run_reg <= 1'b0;
         end else if (take) begin
            cnt_reg <= cnt_reg + AVG_CNT_ONE;
         end
      end
   end

   // ---------------------------------------------
   // Per-word accumulators
   // ---------------------------------------------
   generate
      for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
         logic [ACC_W-1:0] acc_reg;
         wire  [ACC_W-1:0] sum = acc_reg + {{AVG_MAX_LOG2{1'b0}}, raw_flat[w*WORD_BITS +: WORD_BITS]};
         wire  [ACC_W-1:0] shr = sum >> cfg.avg_log2;
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               acc_reg                            <= ACC_RST;
               avg_flat[w*WORD_BITS +: WORD_BITS] <= FRAME_RST[WORD_BITS-1:0];
            end else if (start || last) begin
               acc_reg <= ACC_RST;
               if (last) begin
                  avg_flat[w*WORD_BITS +: WORD_BITS] <= shr[WORD_BITS-1:0];
               end
            end else if (take) begin
               acc_reg <= sum;
            end
         end
      end
   endgenerate

   assign avg = avg_flat;

endmodule // asss_avg

// file: rtl/asss_stream.sv
// Streaming serial port that shifts out ADC sample frames to a host.
// Assumes the host drives select and shift clock; configuration arrives
// from the management bus logic as plain inputs.
//
// Behaviour
// - Configuration stays on management bus; port outputs only.
// - Three signals, shift clock up to 1 MHz.
// - Select low frames one output frame.
// - Mode 0: launch falling, host samples rising.
// - Device drives data only, never select or clock.
// - Fixed 80-bit frame, no header.
// - Select falling edge activates the port.
// - Single-shot: select fall starts a conversion.
// - Select rise stops shifting at once.
// - Each sample goes out MSB first.
// - Data out floats when not transmitting.
// - First bit at select fall, then clock falls.
// - Frame carries the preceding conversion result.
// - Average 2^N samples, N from 0 to 7.
module asss_stream (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Host link pins
   input  wire logic                   stream_select_n,
   input  wire logic                   stream_clock,
   output logic                        stream_data_out,
   output logic                        stream_data_oe_n,
   // Monitor configuration from the management bus
   input  wire asss_pkg::asss_cfg_t    monitor_config_cmd,
   input  wire logic                   monitor_control_cmd,
   // ADC interface
   input  wire asss_pkg::asss_sample_t adc_raw,
   input  wire logic                   adc_raw_valid,
   output logic                        adc_convert_start,
   // Status
   output logic                        frame_active,
   output logic                        frame_complete
);
   import asss_pkg::*;

   // ---------------------------------------------
   // Elaboration checks
   // ---------------------------------------------
   generate
      if (FRAME_BITS != NUM_WORDS * WORD_BITS) begin : g_chk_frame
         $error("frame width does not match word layout");
      end
      if (LINK_HALF_CYC < 2 * SYNC_STAGES) begin : g_chk_rate
         $error("link clock too fast for the sampling clock");
      end
      if (FRAME_BITS > (1 << BIT_IDX_W)) begin : g_chk_idx
         $error("bit index too narrow for the frame");
      end
   endgenerate

   // ---------------------------------------------
   // Link input synchronisers
   // ---------------------------------------------
   asss_link_t link_async;
   asss_link_t link_sync;
   asss_link_t link_prev_reg;

   assign link_async.select_n = stream_select_n;
   assign link_async.clock    = stream_clock;

   asss_sync #(
      .WIDTH    ($bits(asss_link_t)),
      .RST_VAL  (LINK_SYNC_RST)
   ) u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in (link_async),
      .sync_out (link_sync)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link_prev_reg <= LINK_SYNC_RST;
      end else begin
         link_prev_reg <= link_sync;
      end
   end

   // ---------------------------------------------
   // Edge decode
   // ---------------------------------------------
   wire sel_fall = link_prev_reg.select_n & ~link_sync.select_n;
   wire sel_rise = ~link_prev_reg.select_n & link_sync.select_n;
   wire sel_low  = ~link_sync.select_n;
   wire clk_fall = link_prev_reg.clock & ~link_sync.clock;

   // ---------------------------------------------
   // Sample averaging and holding
   // ---------------------------------------------
   asss_sample_t avg_sample;
   logic         avg_valid;
   asss_sample_t latest_reg;
   wire          shot_trig = sel_fall & monitor_config_cmd.single_shot;
   wire          avg_start = shot_trig | monitor_control_cmd;

   asss_avg u_avg (
      .clk       (clk),
      .reset     (reset),
      .cfg       (monitor_config_cmd),
      .start     (avg_start),
      .raw       (adc_raw),
      .raw_valid (adc_raw_valid),
      .avg       (avg_sample),
      .avg_valid (avg_valid)
   );

   // Holds the newest finished result; the frame copies it at select fall,
   // before the conversion started by that same edge can finish.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         latest_reg <= FRAME_RST;
      end else if (avg_valid) begin
         latest_reg <= avg_sample;
      end
   end

   // ---------------------------------------------
   // Frame state machine
   // ---------------------------------------------
   asss_state_t            state_reg;
   asss_state_t            state_next;
   logic [FRAME_BITS-1:0]  shift_reg;
   logic [FRAME_BITS-1:0]  shift_next;
   logic [BIT_IDX_W-1:0]   idx_reg;
   logic [BIT_IDX_W-1:0]   idx_next;
   logic                   drive_next;
   logic                   bit_next;
   logic                   done_next;

   wire                    at_last = (idx_reg == BIT_IDX_LAST);
   wire [FRAME_BITS-1:0]   snap    = latest_reg;
   wire [FRAME_BITS-1:0]   shifted = {shift_reg[FRAME_BITS-2:0], 1'b0};

   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      idx_next   = idx_reg;
      drive_next = 1'b0;
      bit_next   = 1'b0;
      done_next  = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (sel_fall) begin
               state_next = ST_SHIFT;
               shift_next = snap;
               idx_next   = BIT_IDX_RST;
               drive_next = 1'b1;
               bit_next   = snap[FRAME_BITS-1];
            end
         end
         ST_SHIFT: begin
            if (sel_rise || !sel_low) begin
               state_next = ST_IDLE;
            end else if (clk_fall && at_last) begin
               state_next = ST_DONE;
               done_next  = 1'b1;
            end else if (clk_fall) begin
               shift_next = shifted;
               idx_next   = idx_reg + 7'h01;
               drive_next = 1'b1;
               bit_next   = shifted[FRAME_BITS-1];
            end else begin
               drive_next = 1'b1;
               bit_next   = shift_reg[FRAME_BITS-1];
            end
         end
         ST_DONE: begin
            if (!sel_low) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         shift_reg <= FRAME_RST;
         idx_reg   <= BIT_IDX_RST;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         idx_reg   <= idx_next;
      end
   end

   // ---------------------------------------------
   // Registered outputs
   // ---------------------------------------------
   // Only the data pin is ever driven; select and clock are inputs alone.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stream_data_out   <= 1'b0;
         stream_data_oe_n  <= 1'b1;
         adc_convert_start <= 1'b0;
         frame_active      <= 1'b0;
         frame_complete    <= 1'b0;
      end else begin
         stream_data_out   <= bit_next;
         stream_data_oe_n  <= ~drive_next;
         adc_convert_start <= avg_start;
         frame_active      <= drive_next;
         frame_complete    <= done_next;
      end
   end

endmodule // asss_stream

// file: sim/asss_stream_props.sv
// Checker of the sample streaming port, watching the top-level ports only.
// Assumes select stays high for several clocks between frames.
module asss_stream_props (
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   reset,
   // Link pins
   input wire logic                   stream_select_n,
   input wire logic                   stream_clock,
   input wire logic                   stream_data_out,
   input wire logic                   stream_data_oe_n,
   // Configuration and ADC side
   input wire asss_pkg::asss_cfg_t    monitor_config_cmd,
   input wire logic                   monitor_control_cmd,
   input wire asss_pkg::asss_sample_t adc_raw,
   input wire logic                   adc_raw_valid,
   input wire logic                   adc_convert_start,
   // Status
   input wire logic                   frame_active,
   input wire logic                   frame_complete
);
   import asss_pkg::*;
   // ---------------------------------------------
   // Clock falls counted within one select low period
   // ---------------------------------------------
   logic       clock_prev_reg;
   logic [7:0] fall_cnt_reg;
   logic [7:0] fall_cnt_next;
   assign fall_cnt_next = stream_select_n ? 8'h00 :
                          (clock_prev_reg && !stream_clock) ? fall_cnt_reg + 8'h01 : fall_cnt_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clock_prev_reg <= 1'b0;
         fall_cnt_reg   <= 8'h00;
      end else begin
         clock_prev_reg <= stream_clock;
         fall_cnt_reg   <= fall_cnt_next;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   link_enable_a: assert property (frame_active == !stream_data_oe_n)
      else $error("frame_active disagrees with output enable");
   float_low_a: assert property (stream_data_oe_n |-> !stream_data_out)
      else $error("data driven while not enabled");
   select_stop_a: assert property (stream_select_n [*6] |-> stream_data_oe_n)
      else $error("data still enabled after select rose");
   frame_start_a: assert property ($fell(stream_select_n) |-> ##[3:5] frame_active)
      else $error("select fall did not open a frame");
   shot_start_a: assert property ($fell(stream_select_n) && monitor_config_cmd.single_shot |-> ##[3:5] adc_convert_start)
      else $error("select fall did not start a conversion");
   frame_begin_a: assert property ($rose(frame_active) |-> !stream_select_n && fall_cnt_reg == 8'h00)
      else $error("frame opened without a select fall");
   done_float_a: assert property (frame_complete |-> stream_data_oe_n && !stream_select_n)
      else $error("frame end did not release the data line");
   done_pulse_a: assert property (frame_complete |=> !frame_complete)
      else $error("frame end pulse too long");
   done_count_a: assert property (frame_complete |-> fall_cnt_reg == 8'h50)
      else $error("frame ended on a wrong bit count");
   over_run_a: assert property (frame_active |-> fall_cnt_reg <= 8'h50)
      else $error("frame ran past its last bit");
   convert_cmd_a: assert property (monitor_control_cmd |=> adc_convert_start)
      else $error("convert command did not start a conversion");
endmodule // asss_stream_props

bind asss_stream asss_stream_props asss_stream_props_i (
   .clk(clk), .reset(reset), .stream_select_n(stream_select_n), .stream_clock(stream_clock),
   .stream_data_out(stream_data_out), .stream_data_oe_n(stream_data_oe_n),
   .monitor_config_cmd(monitor_config_cmd), .monitor_control_cmd(monitor_control_cmd),
   .adc_raw(adc_raw), .adc_raw_valid(adc_raw_valid), .adc_convert_start(adc_convert_start),
   .frame_active(frame_active), .frame_complete(frame_complete));

// file: sim/asss_host.sv
// Serial host model that frames and clocks the sample streaming port.
// Assumes a 48 ns link clock, started by a go pulse from the bench.
module asss_host (
   // Control from the bench
   input  wire logic       go,
   input  wire logic [7:0] nrise,
   // Link pins
   output logic            select_n,
   output logic            sclk,
   input  wire logic       dout,
   input  wire logic       oe_n,
   // Received bits
   output logic [95:0]     rx,
   output logic [7:0]      rx_count
);
   timeunit 1ns;
   timeprecision 100ps;
   logic line;
   assign line = oe_n ? 1'bz : dout;
   initial begin
      select_n = 1'b1;
      sclk     = 1'b0;
      rx       = '0;
      rx_count = 8'h00;
   end
   // ---------------------------------------------
   // One frame: select, clock pulses, capture before each fall
   // ---------------------------------------------
   always @(posedge go) begin
      #1.3;
      rx = '0;
      select_n = 1'b0;
      #48;
      for (int i = 0; i < nrise; i++) begin
         sclk = 1'b1;
         #24;
         rx = {rx[94:0], line};
         sclk = 1'b0;
         #24;
      end
      #24;
      select_n = 1'b1;
      #48;
      rx_count = rx_count + 8'h01;
   end
endmodule // asss_host

// file: sim/asss_stream_bench.sv
// Self-checking bench of the sample streaming port with a host model.
// Assumes the package, design files, checker and host are compiled first.
module asss_stream_bench import asss_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic         clk, reset, select_n, sclk, dout, oe_n, ctrl, raw_valid, go, conv, act, done;
   asss_cfg_t    cfg;
   asss_sample_t raw, avg_now;
   logic [7:0]   nrise, rx_count, seen_count;
   logic [95:0]  rx;
   logic [95:0]  exp_q[$];
   int           err_count, compares, conv_count;
   int           sums[5];
   always #2.5 clk = ~clk;
   asss_stream asss_stream_i (
      .clk(clk), .reset(reset), .stream_select_n(select_n), .stream_clock(sclk),
      .stream_data_out(dout), .stream_data_oe_n(oe_n), .monitor_config_cmd(cfg),
      .monitor_control_cmd(ctrl), .adc_raw(raw), .adc_raw_valid(raw_valid),
      .adc_convert_start(conv), .frame_active(act), .frame_complete(done));
   asss_host asss_host_i (
      .go(go), .nrise(nrise), .select_n(select_n), .sclk(sclk), .dout(dout), .oe_n(oe_n),
      .rx(rx), .rx_count(rx_count));
   // ---------------------------------------------
   // Checking and closing
   // ---------------------------------------------
   task automatic check(input logic [95:0] got, input logic [95:0] want);
      compares++;
      if (got !== want) begin
         err_count++;
         $display("BAD at %0t: frame %h expected %h", $time, got, want);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic note(input string name);
      $display("test %0s done", name);
   endtask
   always @(posedge clk) begin
      if (rx_count != seen_count) begin
         seen_count <= rx_count;
         if (exp_q.size() == 0) check(rx, '1);
         else check(rx, exp_q.pop_front());
      end
   end
   always @(posedge clk) begin
      if (conv === 1'b1) conv_count <= conv_count + 1;
   end
   // ---------------------------------------------
   // Stimulus tasks
   // ---------------------------------------------
   task automatic feed(input int n, input bit counted);
      logic [95:0] r;
      for (int i = 0; i < n; i++) begin
         r = {$urandom(), $urandom(), $urandom()};
         @(posedge clk);
         raw <= r[79:0];
         raw_valid <= 1'b1;
         if (counted) for (int k = 0; k < 5; k++) sums[k] += r[k*16 +: 16];
         @(posedge clk);
         raw_valid <= 1'b0;
      end
      repeat (4) @(posedge clk);
      if (counted) begin
         for (int k = 0; k < 5; k++) avg_now[k*16 +: 16] = 16'(sums[k] >> cfg.avg_log2);
         sums = '{default: 0};
      end
   endtask
   task automatic frame(input int n, input bit mid);
      logic [95:0] want;
      want = '0;
      for (int k = 0; k < n; k++) want = {want[94:0], (k < FRAME_BITS) ? avg_now[FRAME_BITS-1-k] : 1'bz};
      exp_q.push_back(want);
      @(posedge clk);
      go <= 1'b1;
      nrise <= 8'(n);
      @(posedge clk);
      go <= 1'b0;
      if (mid) begin
         repeat (300) @(posedge clk);
         feed(1, 1'b1);
      end
      for (int t = 0; t < 2000 && exp_q.size() != 0; t++) @(posedge clk);
      if (exp_q.size() != 0) begin
         err_count++;
         $display("BAD at %0t: frame timed out", $time);
         conclude();
      end
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      cfg = '0;
      ctrl = 1'b0;
      raw = '0;
      raw_valid = 1'b0;
      go = 1'b0;
      nrise = 8'h50;
      seen_count = 8'h00;
      avg_now = '0;
      err_count = 0;
      compares = 0;
      conv_count = 0;
      sums = '{default: 0};
      void'($urandom(61120));
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      for (int n = 0; n <= AVG_MAX_LOG2; n++) begin
         cfg <= '{single_shot: 1'b0, avg_log2: 3'(n)};
         @(posedge clk);
         feed(1 << n, 1'b1);
         frame(80, 1'b0);
      end
      note("averaging");
      cfg <= '{single_shot: 1'b0, avg_log2: 3'h0};
      @(posedge clk);
      feed(1, 1'b1);
      frame(16, 1'b0);
      frame(80, 1'b0);
      frame(84, 1'b0);
      note("abort and overrun");
      frame(80, 1'b1);
      frame(80, 1'b0);
      note("snapshot");
      cfg <= '{single_shot: 1'b1, avg_log2: 3'h1};
      @(posedge clk);
      ctrl <= 1'b1;
      @(posedge clk);
      ctrl <= 1'b0;
      feed(2, 1'b1);
      feed(2, 1'b0);
      frame(80, 1'b0);
      feed(2, 1'b1);
      frame(80, 1'b0);
      check(96'(conv_count), 96'(3));
      note("single shot");
      conclude();
   end
endmodule // asss_stream_bench
